// ### rtl/wdc_watchdog_top.sv
// Our own choice: the APB slave port.
`timescale 1ns/10ps
// What this block does
// - 32-bit counter decrements per prescaled tick
// - Zero with reset enabled requests system reset
// - Software picks reset or periodic interrupt
// - Default setup times out near two seconds
// - Load write with enable replaces count
// - Load transfer takes five counter ticks
// - Count register reads counter value one clock late
// - Control at offset eight, reset 0x805C
// - Control bit halts counting during debug
// - Underflow sets software visible flag
// - Interrupt enable gates underflow interrupt
// - Enable starts from load, clear stops
// - Clock select: peripheral or external source
// - Three-bit prescaler code, reset code 100
// - Underflow output pulses at each underflow
// - Reset enable bit six, enable bit four
// - Interrupt mode reloads after each underflow
// - Codes divide by 1,4,8..256
// - Interrupt and readback delayed two clocks max
module wdc_watchdog_top
  import wdc_pkg::*;
#(
  parameter logic [31:0] INIT_COUNT = wdc_pkg::WDC_INIT_COUNT
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        pclkTick,
  input  wire logic        extClkTick,
  input  wire logic        debugHalted,
  output logic             underflowIrq,
  output logic             sysResetReq,
  output logic             underflowPulse
);
  import wdc_pkg::*;

  logic [31:0] control_word_q;
  logic [31:0] reload_value_q;
  logic [31:0] current_count_q;
  logic [31:0] countView_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic        irq_q;
  logic        rstReq_q;
  logic        ufPulse_q;
  logic        cntEnPrev_q;
  logic [2:0]  loadTicks_q;
  wdc_load_e   loadState_q;
  wdc_load_e   loadState_d;

  logic        busAccess;
  logic        busWrite;
  logic        busRead;
  logic        hitReload;
  logic        hitCount;
  logic        hitControl;
  logic        mapped;
  logic        counter_enable_bit;
  logic        underflow_reset_enable;
  logic        underflow_irq_enable;
  logic        underflow_flag;
  logic        debug_halt_control;
  logic        clock_source_select;
  logic [2:0]  prescaler_code;
  logic        counter_input_clock;
  logic        runCounter;
  logic        counter_tick_clock;
  logic        underflowEvt;
  logic        loadWrite;
  logic        loadDone;
  logic        enableRise;

  // Bus decode; pready rises one cycle into the access phase
  assign busAccess  = psel && penable && pready_q;
  assign busWrite   = busAccess && pwrite;
  assign busRead    = psel && penable && !pready_q && !pwrite;
  assign hitReload  = (paddr == WDC_OFF_RELOAD);
  assign hitCount   = (paddr == WDC_OFF_COUNT);
  assign hitControl = (paddr == WDC_OFF_CONTROL);
  assign mapped     = hitReload || hitCount || hitControl;

  // Control fields
  assign counter_enable_bit     = control_word_q[WDC_BIT_CNT_EN];
  assign underflow_reset_enable = control_word_q[WDC_BIT_RST_EN];
  assign underflow_irq_enable   = control_word_q[WDC_BIT_IRQ_EN];
  assign underflow_flag         = control_word_q[WDC_BIT_UF_FLAG];
  assign debug_halt_control     = control_word_q[WDC_BIT_DEBUG_HALT];
  assign clock_source_select    = control_word_q[WDC_BIT_CLK_SEL];
  assign prescaler_code         = control_word_q[WDC_PRS_LSB +: WDC_PRS_W];

  // External source rate is configured outside; only the pick is here
  assign counter_input_clock = clock_source_select ? extClkTick : pclkTick;

  // Halt in debug only when the control bit asks for it
  assign runCounter = counter_enable_bit && !(debug_halt_control && debugHalted);

  wdc_prescaler #(
    .DIV_W (WDC_DIV_W)
  ) u_prescaler (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .run      (runCounter),
    .srcTick  (counter_input_clock),
    .divLimit (wdc_div_limit(prescaler_code)),
    .cntTick  (counter_tick_clock)
  );

  assign underflowEvt = counter_tick_clock && (current_count_q == 32'h0000_0000);
  assign enableRise   = counter_enable_bit && !cntEnPrev_q;

  // Load writes count only while the counter is enabled
  assign loadWrite = busWrite && hitReload && counter_enable_bit;
  assign loadDone  = (loadState_q == WDC_LD_PEND) && counter_tick_clock &&
                     (loadTicks_q == WDC_LOAD_TICKS - 3'h1);

  // Control word; hardware set of the flag beats a clearing write
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      control_word_q <= WDC_CTRL_RESET;
    end else begin
      if (busWrite && hitControl) begin
        control_word_q <= (control_word_q & ~WDC_CTRL_WMASK) | (pwdata & WDC_CTRL_WMASK);
        if (pwdata[WDC_BIT_UF_FLAG]) begin
          control_word_q[WDC_BIT_UF_FLAG] <= 1'b0;
        end
      end
      if (underflowEvt) begin
        control_word_q[WDC_BIT_UF_FLAG] <= 1'b1;
      end
    end
  end

  // Reload register keeps the last accepted load value
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reload_value_q <= WDC_RELOAD_RESET;
    end else if (loadWrite) begin
      reload_value_q <= pwdata;
    end
  end

  // Matches the enable bit's reset value, so reset release is no false enable
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cntEnPrev_q <= 1'b1;
    end else begin
      cntEnPrev_q <= counter_enable_bit;
    end
  end

  // Load transfer sequencer
  always_comb begin
    loadState_d = loadState_q;
    case (loadState_q)
      WDC_LD_IDLE: begin
        if (loadWrite) begin
          loadState_d = WDC_LD_PEND;
        end
      end
      WDC_LD_PEND: begin
        if (loadDone && !loadWrite) begin
          loadState_d = WDC_LD_IDLE;
        end
      end
      default: begin
        loadState_d = WDC_LD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      loadState_q <= WDC_LD_IDLE;
    end else begin
      loadState_q <= loadState_d;
    end
  end

  // A new write restarts the five-tick wait
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      loadTicks_q <= 3'h0;
    end else if (loadWrite) begin
      loadTicks_q <= 3'h0;
    end else if ((loadState_q == WDC_LD_PEND) && counter_tick_clock) begin
      loadTicks_q <= loadTicks_q + 3'h1;
    end
  end

  // Down counter
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      current_count_q <= INIT_COUNT;
    end else if (enableRise) begin
      current_count_q <= reload_value_q;
    end else if (loadDone && !loadWrite) begin
      current_count_q <= reload_value_q;
    end else if (underflowEvt) begin
      // Reset mode parks at zero until the system reset lands
      if (underflow_irq_enable) begin
        current_count_q <= reload_value_q;
      end
    end else if (counter_tick_clock) begin
      current_count_q <= current_count_q - 32'h0000_0001;
    end
  end

  // Snapshot for readback, one clock behind the counter
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      countView_q <= 32'h0000_0000;
    end else begin
      countView_q <= current_count_q;
    end
  end

  // Underflow actions
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ufPulse_q <= 1'b0;
    end else begin
      ufPulse_q <= underflowEvt;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rstReq_q <= 1'b0;
    end else begin
      rstReq_q <= underflowEvt && underflow_reset_enable;
    end
  end

  // Interrupt follows the flag while enabled
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= underflow_irq_enable && (underflow_flag || underflowEvt);
    end
  end

  // APB answer
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= psel && penable && !pready_q;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pslverr_q <= 1'b0;
    end else begin
      pslverr_q <= psel && penable && !pready_q && !mapped;
    end
  end

  // Reload register is write-only and reads as zero
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prdata_q <= 32'h0000_0000;
    end else if (busRead) begin
      if (hitCount) begin
        prdata_q <= countView_q;
      end else if (hitControl) begin
        prdata_q <= control_word_q;
      end else begin
        prdata_q <= 32'h0000_0000;
      end
    end else begin
      // Data stands only alongside pready
      prdata_q <= 32'h0000_0000;
    end
  end

  assign prdata         = prdata_q;
  assign pready         = pready_q;
  assign pslverr        = pslverr_q;
  assign underflowIrq   = irq_q;
  assign sysResetReq    = rstReq_q;
  assign underflowPulse = ufPulse_q;

endmodule

// ### rtl/wdc_pkg.sv
package wdc_pkg;

  // Register byte offsets
  localparam logic [11:0] WDC_OFF_RELOAD  = 12'h000;
  localparam logic [11:0] WDC_OFF_COUNT   = 12'h004;
  localparam logic [11:0] WDC_OFF_CONTROL = 12'h008;

  // Control word field positions
  localparam int WDC_BIT_DEBUG_HALT = 15;
  localparam int WDC_BIT_UF_FLAG    = 8;
  localparam int WDC_BIT_IRQ_EN     = 7;
  localparam int WDC_BIT_RST_EN     = 6;
  localparam int WDC_BIT_CNT_EN     = 4;
  localparam int WDC_BIT_CLK_SEL    = 3;
  localparam int WDC_PRS_LSB        = 0;
  localparam int WDC_PRS_W          = 3;

  // Writable control bits, flag excluded (write one to clear)
  localparam logic [31:0] WDC_CTRL_WMASK = 32'h0000_80DF;
  localparam logic [31:0] WDC_CTRL_RESET = 32'h0000_805C;
  localparam logic [31:0] WDC_RELOAD_RESET = 32'h0000_0000;

  // Load-to-count transfer, in prescaled counter ticks
  localparam logic [2:0] WDC_LOAD_TICKS = 3'h5;

  // Default time-out, assuming the default external source rate
  localparam int          WDC_INIT_TIMEOUT_MS = 2000;
  localparam int          WDC_EXT_CLK_HZ      = 40000;
  localparam int          WDC_INIT_DIVIDE     = 32;
  localparam logic [31:0] WDC_INIT_COUNT =
    32'(WDC_EXT_CLK_HZ / WDC_INIT_DIVIDE * WDC_INIT_TIMEOUT_MS / 1000);

  // Divide ratios per prescaler code, minus one
  localparam int WDC_DIV_W = 8;
  function automatic logic [WDC_DIV_W-1:0] wdc_div_limit(input logic [2:0] code);
    logic [WDC_DIV_W-1:0] lim;
    lim = 8'h00;
    case (code)
      3'h0:    lim = 8'h00;
      3'h1:    lim = 8'h03;
      3'h2:    lim = 8'h07;
      3'h3:    lim = 8'h0F;
      3'h4:    lim = 8'h1F;
      3'h5:    lim = 8'h3F;
      3'h6:    lim = 8'h7F;
      3'h7:    lim = 8'hFF;
      default: lim = 8'h00;
    endcase
    return lim;
  endfunction

  typedef enum logic [0:0] {
    WDC_LD_IDLE = 1'b0,
    WDC_LD_PEND = 1'b1
  } wdc_load_e;

endpackage

// ### rtl/wdc_prescaler.sv
`timescale 1ns/10ps
module wdc_prescaler #(
  parameter int DIV_W = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             run,
  input  wire logic             srcTick,
  input  wire logic [DIV_W-1:0] divLimit,
  output logic                  cntTick
);
  logic [DIV_W-1:0] divCnt_q;

  // Restarts when stopped so the first period after enable is whole
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      divCnt_q <= '0;
    end else if (!run) begin
      divCnt_q <= '0;
    end else if (srcTick) begin
      if (divCnt_q >= divLimit) begin
        divCnt_q <= '0;
      end else begin
        divCnt_q <= divCnt_q + 1'b1;
      end
    end
  end

  assign cntTick = run && srcTick && (divCnt_q >= divLimit);
endmodule

// ### testbench/wdc_watchdog_sva.sv
`timescale 1ns/10ps
module wdc_watchdog_sva (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        sysResetReq,
  input wire logic        underflowPulse
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  rdy_pulse_a: assert property (pready |=> !pready)
    else $error("ready held");
  rdy_timing_a: assert property ($rose(psel) |-> !pready ##1 !pready ##1 pready)
    else $error("ready late");
  rdy_phase_a: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  err_decode_a: assert property (pready |->
    pslverr == !(paddr inside {12'h000, 12'h004, 12'h008}))
    else $error("bad decode");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("data while idle");
  reload_wo_a: assert property (pready && !pwrite && paddr == 12'h000 |-> prdata == 32'h0)
    else $error("reload readable");
  rst_pulse_a: assert property (sysResetReq |-> underflowPulse)
    else $error("reset without underflow");
endmodule

bind wdc_watchdog_top wdc_watchdog_sva chk_u (
  .clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .prdata,
  .pready, .pslverr, .sysResetReq, .underflowPulse
);

// ### testbench/wdc_watchdog_top_tb.sv
`timescale 1ns/10ps
module wdc_watchdog_top_tb;
  import wdc_pkg::*;
  localparam logic [11:0] LDR = WDC_OFF_RELOAD;
  localparam logic [11:0] CNT = WDC_OFF_COUNT;
  localparam logic [11:0] CTL = WDC_OFF_CONTROL;
  logic        clk_sys;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pclkTick;
  logic        extClkTick;
  logic        debugHalted;
  logic        underflowIrq;
  logic        sysResetReq;
  logic        underflowPulse;
  logic        errSeen;
  logic [31:0] rdVal;
  int          failures;
  int          num_checks;
  int          ufN;
  int          rsN;

  wdc_watchdog_top dut_u (
    .clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .pclkTick, .extClkTick, .debugHalted,
    .underflowIrq, .sysResetReq, .underflowPulse
  );

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  always @(negedge clk_sys) begin
    if (underflowPulse === 1'b1) ufN++;
    if (sysResetReq === 1'b1) rsN++;
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic final_report;
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
      final_report();
    end
    // Answer stands until the next rising edge; it is taken here at the falling edge before it
    rdVal = prdata;
    errSeen = pslverr;
    @(posedge clk_sys);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Settle first: count readback lags the counter by a cycle
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    repeat (2) @(posedge clk_sys);
    apb(1'b0, a, 32'h0);
    chk(rdVal, e);
  endtask

  task automatic tick(input logic ext, input int n);
    repeat (n) begin
      @(posedge clk_sys);
      pclkTick <= !ext;
      extClkTick <= ext;
      @(posedge clk_sys);
      pclkTick <= 1'b0;
      extClkTick <= 1'b0;
    end
  endtask

  task automatic t_reset;
    rd(CTL, WDC_CTRL_RESET);
    rd(CNT, WDC_INIT_COUNT);
    rd(LDR, 32'h0);
    rd(12'h00C, 32'h0);
    chk({31'h0, errSeen}, 32'h1);
  endtask

  // Once at zero, each tick underflows, including the one on which the next load lands
  task automatic t_load;
    apb(1'b1, CTL, 32'h8050);
    apb(1'b1, LDR, 32'h0);
    tick(1'b0, 4);
    rd(CNT, WDC_INIT_COUNT - 32'h4);
    tick(1'b0, 1);
    rd(CNT, 32'h0);
    tick(1'b0, 1);
    apb(1'b1, LDR, 32'h14);
    tick(1'b0, 5);
    rd(CNT, 32'h14);
    chk(32'(ufN), 32'h6);
    chk(32'(rsN), 32'h6);
    rd(CTL, 32'h8150);
    apb(1'b1, CTL, 32'h8150);
    rd(CTL, 32'h8050);
  endtask

  task automatic t_ignore;
    apb(1'b1, CTL, 32'h8040);
    tick(1'b0, 3);
    apb(1'b1, LDR, 32'h55);
    rd(CNT, 32'h14);
    apb(1'b1, CTL, 32'h8050);
    rd(CNT, 32'h14);
  endtask

  task automatic t_prescale;
    int e;
    e = 20;
    for (int k = 0; k < 8; k++) begin
      apb(1'b1, CTL, 32'h8050 | k);
      tick(1'b0, 1 << (k == 0 ? 0 : k + 1));
      e--;
      rd(CNT, 32'(e));
    end
    tick(1'b1, 2);
    rd(CNT, 32'(e));
    apb(1'b1, CTL, 32'h8058);
    tick(1'b1, 1);
    tick(1'b0, 1);
    rd(CNT, 32'(e - 1));
  endtask

  task automatic t_debug;
    debugHalted <= 1'b1;
    tick(1'b1, 3);
    rd(CNT, 32'hB);
    apb(1'b1, CTL, 32'h0058);
    tick(1'b1, 2);
    rd(CNT, 32'h9);
    debugHalted <= 1'b0;
  endtask

  task automatic t_irq;
    int uf0;
    int rs0;
    apb(1'b1, CTL, 32'h8090);
    apb(1'b1, LDR, 32'h2);
    tick(1'b0, 7);
    rd(CNT, 32'h0);
    uf0 = ufN;
    rs0 = rsN;
    tick(1'b0, 1);
    repeat (3) @(posedge clk_sys);
    chk({31'h0, underflowIrq}, 32'h1);
    chk(32'(ufN - uf0), 32'h1);
    chk(32'(rsN - rs0), 32'h0);
    rd(CNT, 32'h2);
    rd(CTL, 32'h8190);
    apb(1'b1, CTL, 32'h8190);
    repeat (3) @(posedge clk_sys);
    chk({31'h0, underflowIrq}, 32'h0);
    apb(1'b1, CTL, 32'h8010);
    tick(1'b0, 3);
    repeat (3) @(posedge clk_sys);
    chk({31'h0, underflowIrq}, 32'h0);
    rd(CNT, 32'h0);
    rd(CTL, 32'h8110);
  endtask

  initial begin
    {rst, psel, penable, pwrite, pclkTick, extClkTick, debugHalted} = 7'h40;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_load();
    t_ignore();
    t_prescale();
    t_debug();
    t_irq();
    final_report();
  end
endmodule
